/* src/align_exc_defines.vh */
// Purpose: constants for the alignment exception unit
// Assumes: 32-bit data, big-endian bit numbering (bit 0 = msb)
// Notes:   offsets are byte addresses on the wishbone register bus
`ifndef ALIGN_EXC_DEFINES_VH
`define ALIGN_EXC_DEFINES_VH

// ************************************************
// register offsets
// ************************************************
`define OFS_RET_ADDR     8'h00
`define OFS_SAVED_STATE  8'h04
`define OFS_FAULT_CAUSE  8'h08
`define OFS_FAULT_ADDR   8'h0c
`define OFS_IRQ_STATUS   8'h10
`define OFS_IRQ_MASK     8'h14
`define OFS_CONTROL      8'h18
`define OFS_MACHINE      8'h1c

// ************************************************
// vector formation
// ************************************************
`define ALIGN_VEC_OFS    32'h0000_0600
`define VEC_BASE_HIGH   32'hfff0_0000
`define VEC_BASE_LOW    32'h0000_0000

// ************************************************
// machine state fields (lsb index = 31 - doc bit)
// ************************************************
`define MSR_LE_BIT      0
`define MSR_IP_BIT      6
`define MSR_FP_BIT      13
`define MSR_KEEP_MASK   32'h0000_ffff

// ************************************************
// reset values and status bits
// ************************************************
`define RST_WORD        32'h0000_0000
`define IRQ_EV_TAKEN    0
`define IRQ_EV_FLOAT    1
`define IRQ_EV_MULT     2
`define IRQ_EV_LE       3
`define IRQ_EV_ZERO     4
`define IRQ_W           5

`endif

/* src/align_detect.v */
// Purpose: combinational detection of alignment fault conditions
// Assumes: request fields valid in the cycle i_req is high
// Notes:   page-crossing cases are handled elsewhere
`timescale 1ns/10ps
`default_nettype none
module align_detect (
   input  wire        i_req,
   input  wire [31:0] i_ea,
   input  wire [1:0]  i_size,
   input  wire        i_is_float,
   input  wire        i_is_multi,
   input  wire        i_is_string,
   input  wire        i_is_resv,
   input  wire        i_is_zero,
   input  wire        i_page_wt,
   input  wire        i_page_ci,
   input  wire        i_le_mode,
   input  wire        i_fpu_present,
   output wire [3:0]  o_cause
);
   // misalignment against the natural size (0 byte,1 half,2 word,3 dword)
   wire mis_nat  = (i_size == 2'd1) ? i_ea[0] :
                   (i_size == 2'd2) ? (|i_ea[1:0]) :
                   (i_size == 2'd3) ? (|i_ea[2:0]) : 1'b0;
   wire mis_word = |i_ea[1:0];

   // floating point checks vanish on the reduced variant
   assign o_cause[0] = i_req & i_fpu_present & i_is_float & mis_word; // RL1
   assign o_cause[1] = i_req & (i_is_multi | i_is_resv) & mis_word;  // RL2
   // le traps: any misaligned access, and every multiple or string
   assign o_cause[2] = i_req & i_le_mode &
                       (mis_nat | i_is_multi | i_is_string);   // RL3 RL4
   assign o_cause[3] = i_req & i_is_zero & (i_page_wt | i_page_ci);  // RL5
endmodule
`default_nettype wire

/* src/align_wb_regs.v */
// Purpose: wishbone classic slave decode and ack timing
// Assumes: single cycle requests, ack one clock after strobe
// Notes:   ack drops in the cycle after it is given
`timescale 1ns/10ps
`default_nettype none
module align_wb_regs (
   input  wire       i_ref_clk,
   input  wire       i_rst,
   input  wire       i_cyc,
   input  wire       i_stb,
   input  wire       i_we,
   output wire       o_wr_go,
   output wire       o_rd_go,
   output reg        o_ack
);
   // a write lands on the edge where the master sees ack high, once;
   // a read is latched one edge earlier so its data stands with ack
   assign o_wr_go = i_cyc & i_stb & i_we & o_ack;
   assign o_rd_go = i_cyc & i_stb & ~i_we & ~o_ack;

   // ack pulse lasts one cycle so a held strobe is acted at most every second cycle
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_ack <= 1'b0;
      end else begin
         o_ack <= i_cyc & i_stb & ~o_ack;
      end
   end
endmodule
`default_nettype wire

/* src/align_exc_unit.v */
// Purpose: alignment exception unit of a 32-bit risc core
// Assumes: request fields arrive with i_req from the issue stage
// Notes:   bits numbered msb = 0 in comments, as the core does
// Function
// RL1: misaligned floating load or store traps; skipped without a float unit.
// RL2: misaligned load/store multiple or reservation access traps.
// RL3: with byte reversal mode set, any misaligned access traps.
// RL4: multiple or string access with byte reversal mode set always traps.
// RL5: cache-block-zero to write-through or inhibited page traps.
// RL6: return address register takes the faulting instruction address.
// RL7: saved state low half cleared, high half copied from machine state.
// RL8: fault cause bits 0 to 14 are cleared.
// RL9: cause bits 15-16 from instruction 29-30 indexed, else zero.
// RL10: cause bit 17 from instruction bit 25 indexed, bit 5 immediate.
// RL11: cause bits 18-21 from instruction 21-24 indexed, 1-4 immediate.
// RL12: cause bits 22-26 copy instruction register field bits 6-10.
// RL13: cause bits 27-31 copy base field for load multiple and strings.
// RL14: fault address register takes the computed data address.
// RL15: taken exception goes to vector offset 0x600.
// RL16: without float hardware the float-available bit stays zero.
// RL17: handlers should treat unaligned reservation accesses as errors.
// RL18: fetch address is vector offset plus base chosen by vector select.
// RL19: detection happens before the access changes any state.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "align_exc_defines.vh"
module align_exc_unit (
   input  wire        i_ref_clk,
   input  wire        i_rst,
   // wishbone classic slave
   input  wire        i_wb_cyc,
   input  wire        i_wb_stb,
   input  wire        i_wb_we,
   input  wire [7:0]  i_wb_adr,
   input  wire [3:0]  i_wb_sel,
   input  wire [31:0] i_wb_dat,
   output reg  [31:0] o_wb_dat,
   output wire        o_wb_ack,
   // access request from the load/store path
   input  wire        i_req,
   input  wire [31:0] i_inst_addr,
   input  wire [31:0] i_inst,
   input  wire [31:0] i_ea,
   input  wire [1:0]  i_size,
   input  wire        i_is_indexed,
   input  wire        i_is_float,
   input  wire        i_is_multi,
   input  wire        i_is_string,
   input  wire        i_is_ld_base,
   input  wire        i_is_resv,
   input  wire        i_is_zero,
   input  wire        i_page_wt,
   input  wire        i_page_ci,
   input  wire        i_fpu_present,
   // results to the core
   output wire        o_block,
   output reg         o_take,
   output reg  [31:0] o_vector,
   output wire [31:0] o_machine_state,
   output wire        o_irq
);
   // ************************************************
   // storage
   // ************************************************
   reg  [31:0] exception_return_address_r;
   reg  [31:0] exception_saved_state_r;
   reg  [31:0] data_fault_cause_r;
   reg  [31:0] data_fault_address_r;
   reg  [31:0] machine_state_reg_r;
   reg  [`IRQ_W-1:0] irq_status_r;
   reg  [`IRQ_W-1:0] irq_mask_r;
   reg         unit_enable_r;
   reg  [31:0] cause_nxt;
   reg  [31:0] wdat;
   reg  [31:0] rd_mux;
   wire [3:0]  cause_vec;
   wire        wr_go;
   wire        rd_go;
   wire        fault;
   wire        le_mode;
   integer     k;
   integer     j;

   // ************************************************
   // helpers
   // ************************************************
   // msb-zero numbering: doc bit n lives at index 31-n
   function inst_bit;
      input [31:0] w;
      input integer n;
      begin
         inst_bit = w[31-n];
      end
   endfunction

   assign le_mode = machine_state_reg_r[`MSR_LE_BIT];

   // ************************************************
   // detection and bus
   // ************************************************
   align_detect align_detect_i (
      .i_req         (i_req & unit_enable_r),
      .i_ea          (i_ea),
      .i_size        (i_size),
      .i_is_float    (i_is_float),
      .i_is_multi    (i_is_multi),
      .i_is_string   (i_is_string),
      .i_is_resv     (i_is_resv),
      .i_is_zero     (i_is_zero),
      .i_page_wt     (i_page_wt),
      .i_page_ci     (i_page_ci),
      .i_le_mode     (le_mode),
      .i_fpu_present (i_fpu_present),
      .o_cause       (cause_vec)
   );

   align_wb_regs align_wb_regs_i (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_cyc     (i_wb_cyc),
      .i_stb     (i_wb_stb),
      .i_we      (i_wb_we),
      .o_wr_go   (wr_go),
      .o_rd_go   (rd_go),
      .o_ack     (o_wb_ack)
   );

   assign fault = |cause_vec;
   // combinational block tells the core to suppress the access now
   assign o_block = fault;   // RL19
   assign o_irq = |(irq_status_r & irq_mask_r);
   // float-available forced low without an fpu
   assign o_machine_state = machine_state_reg_r &
                            ~({31'h0000_0000, ~i_fpu_present} << `MSR_FP_BIT); // RL16

   // ************************************************
   // fault cause assembly
   // ************************************************
   // bits 0..14 stay zero; indexed and immediate forms pick fields
   always @* begin
      cause_nxt = 32'h0000_0000; // RL8
      if (i_is_indexed) begin
         cause_nxt[31-15] = inst_bit(i_inst, 29); // RL9
         cause_nxt[31-16] = inst_bit(i_inst, 30); // RL9
         cause_nxt[31-17] = inst_bit(i_inst, 25); // RL10
         for (k = 0; k < 4; k = k + 1) begin
            cause_nxt[31-18-k] = inst_bit(i_inst, 21+k); // RL11
         end
      end else begin
         cause_nxt[31-17] = inst_bit(i_inst, 5); // RL10
         for (k = 0; k < 4; k = k + 1) begin
            cause_nxt[31-18-k] = inst_bit(i_inst, 1+k); // RL11
         end
      end
      // register field copied always; undefined use for cache-zero is harmless
      cause_nxt[9:5] = i_inst[25:21]; // RL12
      // base field only meaningful for load multiple and load string
      if (i_is_ld_base) begin
         cause_nxt[4:0] = i_inst[20:16]; // RL13
      end
   end

   // ************************************************
   // write data with byte lanes
   // ************************************************
   always @* begin
      wdat = rd_mux;
      // own loop index: sharing one with the cause process would give it two drivers
      for (j = 0; j < 4; j = j + 1) begin
         if (i_wb_sel[j]) begin
            wdat[8*j +: 8] = i_wb_dat[8*j +: 8];
         end
      end
   end

   // ************************************************
   // read mux; unmapped reads return zero
   // ************************************************
   always @* begin
      if (i_wb_adr == `OFS_RET_ADDR) begin
         rd_mux = exception_return_address_r;
      end else if (i_wb_adr == `OFS_SAVED_STATE) begin
         rd_mux = exception_saved_state_r;
      end else if (i_wb_adr == `OFS_FAULT_CAUSE) begin
         rd_mux = data_fault_cause_r;
      end else if (i_wb_adr == `OFS_FAULT_ADDR) begin
         rd_mux = data_fault_address_r;
      end else if (i_wb_adr == `OFS_IRQ_STATUS) begin
         rd_mux = {27'h000_0000, irq_status_r};
      end else if (i_wb_adr == `OFS_IRQ_MASK) begin
         rd_mux = {27'h000_0000, irq_mask_r};
      end else if (i_wb_adr == `OFS_CONTROL) begin
         rd_mux = {31'h0000_0000, unit_enable_r};
      end else if (i_wb_adr == `OFS_MACHINE) begin
         rd_mux = o_machine_state;
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   // ************************************************
   // registers, capture on fault wins over software write
   // ************************************************
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         exception_return_address_r <= `RST_WORD;
         exception_saved_state_r    <= `RST_WORD;
         data_fault_cause_r         <= `RST_WORD;
         data_fault_address_r       <= `RST_WORD;
         machine_state_reg_r        <= `RST_WORD;
         irq_mask_r                 <= {`IRQ_W{1'b0}};
         unit_enable_r              <= 1'b1;
         o_take                     <= 1'b0;
         o_vector                   <= `RST_WORD;
         o_wb_dat                   <= `RST_WORD;
      end else begin
         o_take <= fault;
         if (rd_go) begin
            o_wb_dat <= rd_mux;
         end
         if (wr_go) begin
            if (i_wb_adr == `OFS_RET_ADDR) begin
               exception_return_address_r <= wdat;
            end else if (i_wb_adr == `OFS_SAVED_STATE) begin
               exception_saved_state_r <= wdat;
            end else if (i_wb_adr == `OFS_FAULT_CAUSE) begin
               data_fault_cause_r <= wdat;
            end else if (i_wb_adr == `OFS_FAULT_ADDR) begin
               data_fault_address_r <= wdat;
            end else if (i_wb_adr == `OFS_IRQ_MASK) begin
               irq_mask_r <= wdat[`IRQ_W-1:0];
            end else if (i_wb_adr == `OFS_CONTROL) begin
               unit_enable_r <= wdat[0];
            end else if (i_wb_adr == `OFS_MACHINE) begin
               machine_state_reg_r <= wdat;
            end
         end
         if (fault) begin
            exception_return_address_r <= i_inst_addr; // RL6
            // low half cleared, high half from machine state
            exception_saved_state_r <= o_machine_state & `MSR_KEEP_MASK; // RL7
            data_fault_cause_r   <= cause_nxt;
            data_fault_address_r <= i_ea; // RL14
            // handler entry: base picked by vector select, plus offset
            o_vector <= (machine_state_reg_r[`MSR_IP_BIT] ? `VEC_BASE_HIGH :
                         `VEC_BASE_LOW) + `ALIGN_VEC_OFS; // RL15 RL18
         end
      end
   end

   // ************************************************
   // sticky status, read clears, new event wins
   // ************************************************
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         irq_status_r <= {`IRQ_W{1'b0}};
      end else begin
         irq_status_r <= (rd_go && i_wb_adr == `OFS_IRQ_STATUS) ?
                         {`IRQ_W{1'b0}} | {cause_vec, fault} :
                         irq_status_r | {cause_vec, fault};
      end
   end
endmodule
`default_nettype wire

/* tb/align_exc_unit_assertions.sv */
// Purpose: port assertions for the alignment exception unit
// Assumes: one clock domain, synchronous active-high reset
// Notes:   enable is not visible; word_align_a and rev_multi_a still expect o_block, so they assume the unit is enabled
`timescale 1ns/10ps
`default_nettype none
`include "align_exc_defines.vh"
module align_exc_unit_assertions (
   input wire logic        i_ref_clk,
   input wire logic        i_rst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        o_wb_ack,
   input wire logic        i_req,
   input wire logic [31:0] i_ea,
   input wire logic        i_is_multi,
   input wire logic        i_is_resv,
   input wire logic        i_is_string,
   input wire logic        i_fpu_present,
   input wire logic        o_block,
   input wire logic        o_take,
   input wire logic [31:0] o_vector,
   input wire logic [31:0] o_machine_state
);
   // *****
   // properties
   // *****
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   take_after_block_a: assert property (o_block |=> o_take)
      else $error("no take after block");
   take_has_cause_a: assert property (o_take |-> $past(o_block))
      else $error("take without block");
   vector_value_a: assert property (o_take |-> o_vector == ((o_machine_state[`MSR_IP_BIT] ?
      `VEC_BASE_HIGH : `VEC_BASE_LOW) + `ALIGN_VEC_OFS)) else $error("bad vector");
   vector_hold_a: assert property (!o_take |-> $stable(o_vector))
      else $error("vector moved");
   float_off_a: assert property (!i_fpu_present |-> !o_machine_state[`MSR_FP_BIT])
      else $error("float bit set");
   word_align_a: assert property (i_req && (i_is_multi || i_is_resv) && i_ea[1:0] != 2'b00
      |-> o_block) else $error("misaligned multiple passed");
   rev_multi_a: assert property (i_req && o_machine_state[`MSR_LE_BIT]
      && (i_is_multi || i_is_string) |-> o_block) else $error("reversed multiple passed");
   ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack late");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack too long");
   ack_idle_a: assert property (!i_wb_cyc |=> !o_wb_ack)
      else $error("ack without cycle");
endmodule
bind align_exc_unit align_exc_unit_assertions align_exc_unit_assertions_i (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .o_wb_ack(o_wb_ack), .i_req(i_req), .i_ea(i_ea), .i_is_multi(i_is_multi),
   .i_is_resv(i_is_resv), .i_is_string(i_is_string), .i_fpu_present(i_fpu_present),
   .o_block(o_block), .o_take(o_take), .o_vector(o_vector), .o_machine_state(o_machine_state));
`default_nettype wire

/* tb/alignment_exception_unit_tb.sv */
// Purpose: self-checking bench for the alignment exception unit
// Assumes: wishbone ack one cycle after strobe, capture one cycle after request
// Notes:   row = {rev,fpu,idx,flt,mul,str,ldb,rsv,zero,wt,ci,size,ea[2:0]}
`timescale 1ns/10ps
`default_nettype none
module alignment_exception_unit_tb;
   logic        i_ref_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_req, i_is_indexed, i_is_float;
   logic        i_is_multi, i_is_string, i_is_ld_base, i_is_resv, i_is_zero, i_page_wt;
   logic        i_page_ci, i_fpu_present, o_wb_ack, o_block, o_take, o_irq;
   logic [1:0]  i_size;
   logic [3:0]  i_wb_sel;
   logic [7:0]  i_wb_adr;
   logic [31:0] i_wb_dat, o_wb_dat, i_inst_addr, i_inst, i_ea, o_vector, o_machine_state, rd;
   logic [15:0] rows [14];
   int          num_errors, n_tests, i;

   align_exc_unit align_exc_unit_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
      .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_req(i_req),
      .i_inst_addr(i_inst_addr), .i_inst(i_inst), .i_ea(i_ea), .i_size(i_size),
      .i_is_indexed(i_is_indexed), .i_is_float(i_is_float), .i_is_multi(i_is_multi),
      .i_is_string(i_is_string), .i_is_ld_base(i_is_ld_base), .i_is_resv(i_is_resv),
      .i_is_zero(i_is_zero), .i_page_wt(i_page_wt), .i_page_ci(i_page_ci),
      .i_fpu_present(i_fpu_present), .o_block(o_block), .o_take(o_take), .o_vector(o_vector),
      .o_machine_state(o_machine_state), .o_irq(o_irq));

   // 25 mhz clock
   always #20 i_ref_clk = ~i_ref_clk;

   // *****
   // shared tasks
   // *****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("mismatches=%0d checks=%0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // one classic cycle; ack and read data are taken at the rising edge, then released
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_ref_clk);
      {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, we, a, d};
      for (k = 0; k < 20; k++) begin
         @(posedge i_ref_clk);
         if (o_wb_ack === 1'b1) break;
      end
      if (k == 20) begin
         num_errors++;
         report_and_stop();
      end
      rd = o_wb_dat;
      {i_wb_cyc, i_wb_stb} <= 2'b00;
   endtask

   // register defaults, with a stray write and read at an unmapped place
   task automatic reg_defaults;
      int a;
      wb(1'b1, 8'h20, 32'hffff_ffff);
      for (a = 0; a < 9; a++) begin
         wb(1'b0, 8'(4 * a), 32'h0);
         chk(rd, {31'h0, a == 6});
      end
   endtask

   // one request row; expectations rebuilt from the trap conditions
   task automatic run(input logic [15:0] r, input int n, input logic en, input logic mk);
      logic [31:0] ea, ins, ia, m;
      logic [4:0]  ex;
      logic        mis;
      ea  = {16'habcd, 8'(n), 5'h0, r[2:0]};
      ins = 32'ha5c3_5e69 + n * 32'h1111_1111;
      ia  = 32'h0000_1000 + 4 * n;
      m   = 32'h0000_2000 | {25'h0, n[0], 6'h0} | {31'h0, r[15]};
      mis = r[4:3] == 2'd1 ? r[0] : r[4:3] == 2'd2 ? |r[1:0] : r[4:3] == 2'd3 ? |r[2:0] : 1'b0;
      ex  = {r[7] & (r[6] | r[5]), r[15] & (mis | r[11] | r[10]), (r[11] | r[8]) & |r[1:0],
             r[12] & r[14] & |r[1:0], 1'b0};
      ex[0] = |ex[4:1] & en;
      ex = ex[0] ? ex : 5'h0;
      wb(1'b1, 8'h1c, m);
      @(posedge i_ref_clk);
      {i_req, i_is_indexed, i_is_float, i_is_multi, i_is_string, i_is_ld_base, i_is_resv,
       i_is_zero, i_page_wt, i_page_ci, i_size} <= {1'b1, r[13:3]};
      {i_ea, i_inst, i_inst_addr, i_fpu_present} <= {ea, ins, ia, r[14]};
      @(negedge i_ref_clk);
      chk(o_machine_state, r[14] ? m : m & ~32'h2000);
      chk(o_block, ex[0]);
      @(posedge i_ref_clk);
      i_req <= 1'b0;
      @(negedge i_ref_clk);
      chk(o_take, ex[0]);
      chk(o_irq, ex[0] & mk);
      if (ex[0]) begin
         chk(o_vector, (n[0] ? 32'hfff0_0000 : 32'h0) + 32'h600);
         wb(1'b0, 8'h00, 32'h0);
         chk(rd, ia);
         wb(1'b0, 8'h04, 32'h0);
         chk(rd, {16'h0, r[14] ? m[15:0] : m[15:0] & 16'hdfff});
         wb(1'b0, 8'h08, 32'h0);
         chk(rd, {15'h0, r[13] ? ins[2:1] : 2'b0, r[13] ? ins[6] : ins[26],
                  r[13] ? ins[10:7] : ins[30:27], ins[25:21], r[9] ? ins[20:16] : 5'h0});
         wb(1'b0, 8'h0c, 32'h0);
         chk(rd, ea);
      end
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, {27'h0, ex});
      @(negedge i_ref_clk);
      chk(o_irq, 1'b0);
   endtask

   // *****
   // main sequence
   // *****
   initial begin
      {i_ref_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_req, i_is_indexed, i_is_float,
       i_is_multi, i_is_string, i_is_ld_base, i_is_resv, i_is_zero, i_page_wt, i_page_ci,
       i_fpu_present} = 16'h4000;
      {i_size, i_wb_sel, i_wb_adr, i_wb_dat, i_inst_addr, i_inst, i_ea} = {6'h0f, 136'h0};
      num_errors = 0;
      n_tests = 0;
      rows = '{16'h7012, 16'h1012, 16'h5014, 16'h6a11, 16'h4112, 16'h6110, 16'hc009,
               16'he003, 16'hc01c, 16'he610, 16'h6012, 16'h40c0, 16'h60a0, 16'h4080};
      repeat (3) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      reg_defaults();
      wb(1'b1, 8'h00, 32'h1234_5678);
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1234_5678);
      // byte lanes: only the two low lanes of this write may land
      i_wb_sel <= 4'h3;
      wb(1'b1, 8'h00, 32'hffff_aaaa);
      i_wb_sel <= 4'hf;
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1234_aaaa);
      // misaligned reservation rows are only reported, never replayed as a handler would
      for (i = 0; i < 14; i++) run(rows[i], i, 1'b1, 1'b0);
      // trapping disabled: a cache-zero fault must pass silently
      wb(1'b1, 8'h18, 32'h0);
      run(rows[11], 11, 1'b0, 1'b0);
      wb(1'b1, 8'h18, 32'h1);
      // unmasked event drives the interrupt until status is read
      wb(1'b1, 8'h14, 32'h1);
      run(rows[3], 3, 1'b1, 1'b1);
      run(rows[9], 9, 1'b1, 1'b1);
      // reset in mid-run wipes captured state and the mask
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(negedge i_ref_clk);
      chk(o_take, 1'b0);
      chk(o_irq, 1'b0);
      chk(o_wb_ack, 1'b0);
      reg_defaults();
      report_and_stop();
   end
endmodule
`default_nettype wire
